// ---- rtl/emif_timing_ctrl.sv ----
`default_nettype none
module emif_timing_ctrl (
	input  wire logic        mclk,                  // CPU clock, 25 MHz
	input  wire logic        rst,                   // Sync reset, high
	input  wire logic [15:0] reg_addr,              // I/O word address
	input  wire logic        reg_wr,                // Write strobe
	input  wire logic        reg_rd,                // Read strobe
	input  wire logic [15:0] reg_wdata,             // Write data
	output logic [15:0]      reg_rdata,             // Read data, registered
	input  wire logic        acc_req,               // Access request level
	input  wire logic [1:0]  acc_space,             // Target space
	input  wire logic        acc_write,             // 1 write, 0 read
	input  wire logic [2:0]  acc_source,            // Requesting bus index
	output logic             acc_done,              // Access finished pulse
	output logic             acc_error,             // Timed out, with done
	input  wire logic        async_ready,           // External ready
	output logic             memory_clock,          // Memory clock pin
	output logic             space0_select_n,       // Space 0 select
	output logic             space1_select_n,       // Space 1 select
	output logic             space2_select_n,       // Space 2 select
	output logic             space3_select_n,       // Space 3 select
	output logic             async_write_strobe_n,  // Async write strobe
	output logic             async_read_strobe_n,   // Async read strobe
	output logic             async_output_enable_n, // Async output enable
	output logic [2:0]       async_kind,            // Kind of active space
	output logic             row_strobe_n,          // SDRAM row strobe
	output logic             column_strobe_n,       // SDRAM column strobe
	output logic             sdram_we_n,            // SDRAM write enable
	output logic             sdram_all_banks,       // A10 during commands
	output logic             upper_lanes_on,        // Data on D[31:16] too
	output logic             part_width_x32,        // Part is x32
	output logic             part_density_hi        // Part is 128 Mbit
);
	import emif_cfg_pkg::*;

	typedef enum {SD_INIT_DEACT, SD_INIT_MODE, SD_IDLE, SD_ACT, SD_RW, SD_DEACT,
		SD_DONE} sd_state_e;
	typedef enum {AS_IDLE, AS_SETUP, AS_STROBE, AS_HOLD} as_state_e;

	typedef struct packed {
		logic [15:0]       gctl;
		logic [3:0][15:0]  sp1;
		logic [3:0][15:0]  sp2;
		logic [3:0][15:0]  sp3;
		logic [15:0]       sd1;
		logic [15:0]       sd2;
		logic [15:0]       interval;
		logic [15:0]       bus_err;
		logic [15:0]       rdata;
		sd_state_e         sd;
		logic [3:0]        gap;
		logic [3:0]        ras_cnt;
		logic [3:0]        rrd_cnt;
		logic [2:0]        turn_cnt;
		logic              last_wr;
		logic              sd_busy;
		as_state_e         as;
		logic [5:0]        phase_cnt;
		logic [7:0]        tmo_cnt;
		logic [3:0]        sel_n;
		logic [2:0]        cmd;
		logic              a10;
		logic              we_strb_n;
		logic              rd_strb_n;
		logic              oe_n;
		logic [2:0]        kind;
		logic              done;
		logic              err;
	} ctrl_state_s;

	// Command codes on row, column, write-enable
	localparam logic [2:0] CMD_NOP   = 3'h7;
	localparam logic [2:0] CMD_ACT   = 3'h3;
	localparam logic [2:0] CMD_READ  = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_DEACT = 3'h2;
	localparam logic [2:0] CMD_REFRESH_CMD  = 3'h1;
	localparam logic [2:0] CMD_MODE  = 3'h0;

	ctrl_state_s r;
	ctrl_state_s n;
	logic        mem_tick;
	logic        restart;
	logic        refresh_req;
	logic        refresh_taken;
	logic [15:0] countdown;
	logic [3:0]  sdram_spaces;
	logic        hit_space;
	logic [1:0]  hit_idx;
	logic [1:0]  hit_sub;

	// Space register decode, shared by read and write paths
	function automatic logic [4:0] space_decode(input logic [15:0] addr);
		logic [4:0] res;
		res = 5'h00;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 3; j++) begin
				if (addr == ADDR_SPACE_BASE + 16'(3 * i + j)) begin
					res = {1'b1, 2'(i), 2'(j)};
				end
			end
		end
		return res;
	endfunction

	// Field extraction of a 4-bit timing value
	function automatic logic [3:0] nib(input logic [15:0] v, input int lsb);
		return 4'(v >> lsb);
	endfunction

	assign {hit_space, hit_idx, hit_sub} = space_decode(reg_addr);
	assign restart = reg_wr && (reg_addr == ADDR_SM_RESET);

	mem_clock_gen u_clk (
		.mclk            (mclk),
		.rst             (rst),
		.mem_clock_ratio (r.gctl[RATIO_LSB +: 3]),
		.mem_clock_on    (r.gctl[CLK_ON_BIT]),
		.mem_tick        (mem_tick),
		.memory_clock    (memory_clock)
	);

	refresh_countdown_unit #(
		.CW (16)
	) u_refresh (
		.mclk        (mclk),
		.rst         (rst),
		.restart     (restart),
		.mem_tick    (mem_tick),
		.interval    (r.interval),
		.refresh_on  (r.sd1[REFRESH_ON_BIT]),
		.taken       (refresh_taken),
		.count       (countdown),
		.refresh_req (refresh_req)
	);

	// Spaces that take SDRAM commands, from one shared setting set
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sdram_spaces[i] = (r.sp1[i][KIND_LSB +: 3] == KIND_SDRAM);
		end
	end

	// Register file, SDRAM sequencer and asynchronous strobe engine
	always_comb begin
		logic       is_sd;
		logic [1:0] sp;
		logic [15:0] tim;
		n = r;
		refresh_taken = 1'b0;
		sp = acc_space;
		is_sd = sdram_spaces[sp];
		tim = acc_write ? r.sp2[sp] : r.sp1[sp];
		n.done = 1'b0;
		n.err = 1'b0;

		// Register writes; configuration survives an engine restart
		if (reg_wr) begin
			if (reg_addr == ADDR_GLOBAL_CTRL) begin
				n.gctl = reg_wdata & 16'h0E20;
			end
			if (hit_space && hit_sub == 2'h0) begin
				n.sp1[hit_idx] = reg_wdata & 16'h7FFF;
			end
			if (hit_space && hit_sub == 2'h1) begin
				n.sp2[hit_idx] = reg_wdata & 16'h0FFF;
			end
			if (hit_space && hit_sub == 2'h2) begin
				n.sp3[hit_idx] = reg_wdata & 16'h00FF;
			end
			if (reg_addr == ADDR_SD_CTRL1) begin
				n.sd1 = reg_wdata;
			end
			if (reg_addr == ADDR_SD_CTRL2) begin
				n.sd2 = reg_wdata & 16'h1FFF;
			end
			if (reg_addr == ADDR_INTERVAL) begin
				n.interval = reg_wdata;
			end
		end

		// Read data; status clears on read, new errors still land
		if (reg_rd) begin
			n.rdata = 16'h0000;
			if (reg_addr == ADDR_GLOBAL_CTRL) n.rdata = r.gctl;
			if (reg_addr == ADDR_BUS_ERR) begin
				n.rdata = r.bus_err;
				n.bus_err = 16'h0000;
			end
			if (hit_space) begin
				case (hit_sub)
					2'h0: n.rdata = r.sp1[hit_idx];
					2'h1: n.rdata = r.sp2[hit_idx];
					default: n.rdata = r.sp3[hit_idx];
				endcase
			end
			if (reg_addr == ADDR_SD_CTRL1) n.rdata = r.sd1;
			if (reg_addr == ADDR_SD_CTRL2) n.rdata = r.sd2;
			if (reg_addr == ADDR_INTERVAL) n.rdata = r.interval;
			if (reg_addr == ADDR_COUNTDOWN) n.rdata = countdown;
		end

		// SDRAM sequencer, everything counted in memory clocks
		if (mem_tick) begin
			n.cmd = CMD_NOP;
			n.a10 = 1'b0;
			n.sel_n[3:0] = r.as == AS_IDLE ? 4'hF : r.sel_n;
			if (r.gap != 4'h0) n.gap = r.gap - 4'h1;
			if (r.ras_cnt != 4'h0) n.ras_cnt = r.ras_cnt - 4'h1;
			if (r.rrd_cnt != 4'h0) n.rrd_cnt = r.rrd_cnt - 4'h1;
			if (r.turn_cnt != 3'h0) n.turn_cnt = r.turn_cnt - 3'h1;
			if (r.gap == 4'h0) begin
				case (r.sd)
					SD_INIT_DEACT: begin
						n.cmd = CMD_DEACT;
						n.a10 = 1'b1;
						n.sel_n = ~sdram_spaces;
						n.gap = nib(r.sd1, TRP_LSB);
						n.sd = SD_INIT_MODE;
					end
					SD_INIT_MODE: begin
						n.cmd = CMD_MODE;
						n.sel_n = ~sdram_spaces;
						n.gap = nib(r.sd2, TMRD_LSB);
						n.sd = SD_IDLE;
					end
					SD_IDLE: begin
						// Accesses win; refresh trickles in only when none waits
						if (acc_req && is_sd && r.as == AS_IDLE && r.rrd_cnt == 4'h0) begin
							n.cmd = CMD_ACT;
							n.sel_n = ~(4'h1 << sp);
							n.gap = nib(r.sd1, TRCD_LSB);
							n.ras_cnt = nib(r.sd2, TRAS_LSB);
							n.rrd_cnt = nib(r.sd2, ACT_SPACING_LSB);
							n.sd = SD_RW;
						end else if (refresh_req && !acc_req && r.as == AS_IDLE) begin
							// Any waiting access blocks it, so selects never mix
							refresh_taken = 1'b1;
							n.cmd = CMD_REFRESH_CMD;
							n.sel_n = ~sdram_spaces;
							n.gap = nib(r.sd1, TRC_LSB);
						end
					end
					SD_RW: begin
						// Direction change waits out the turnaround count
						if (r.turn_cnt == 3'h0 || r.last_wr == acc_write) begin
							n.cmd = acc_write ? CMD_WRITE : CMD_READ;
							n.sel_n = ~(4'h1 << sp);
							n.last_wr = acc_write;
							n.turn_cnt = 3'(TURN_GAP - 1);
							n.gap = 4'(RW_TO_DEACT - 1);
							n.sd = SD_DEACT;
						end
					end
					SD_DEACT: begin
						// Read data lands after the fixed latency, before this point
						if (r.ras_cnt == 4'h0) begin
							n.cmd = CMD_DEACT;
							n.a10 = 1'b1;
							n.sel_n = ~sdram_spaces;
							n.gap = nib(r.sd1, TRP_LSB);
							n.sd = SD_DONE;
						end
					end
					SD_DONE: begin
						n.done = 1'b1;
						n.sd = SD_IDLE;
					end
					default: n.sd = SD_IDLE;
				endcase
			end
		end

		// Asynchronous engine, counted in CPU clocks
		case (r.as)
			AS_IDLE: begin
				if (acc_req && !is_sd && r.sd == SD_IDLE && r.cmd == CMD_NOP && !r.done) begin
					n.as = AS_SETUP;
					n.sel_n = ~(4'h1 << sp);
					n.kind = r.sp1[sp][KIND_LSB +: 3];
					n.oe_n = acc_write;
					n.phase_cnt = {2'h0, nib(tim, SETUP_LSB)};
					n.tmo_cnt = 8'h01;
				end
			end
			AS_SETUP: begin
				if (r.phase_cnt <= 6'h1) begin
					n.as = AS_STROBE;
					n.phase_cnt = 6'(tim >> STROBE_LSB);
					n.we_strb_n = ~acc_write;
					n.rd_strb_n = acc_write;
				end else begin
					n.phase_cnt = r.phase_cnt - 6'h1;
				end
			end
			AS_STROBE: begin
				if (r.phase_cnt > 6'h1) n.phase_cnt = r.phase_cnt - 6'h1;
				if (r.phase_cnt <= 6'h1 && async_ready) begin
					n.as = AS_HOLD;
					n.phase_cnt = {4'h0, tim[1:0]};
					n.we_strb_n = 1'b1;
					n.rd_strb_n = 1'b1;
				end
			end
			AS_HOLD: begin
				if (r.phase_cnt <= 6'h1) begin
					n.as = AS_IDLE;
					n.sel_n = 4'hF;
					n.oe_n = 1'b1;
					n.done = 1'b1;
				end else begin
					n.phase_cnt = r.phase_cnt - 6'h1;
				end
			end
			default: n.as = AS_IDLE;
		endcase

		// Timeout across setup and strobe; zero turns the timer off
		if ((r.as == AS_SETUP || r.as == AS_STROBE) && r.sp3[sp][7:0] != 8'h00) begin
			n.tmo_cnt = r.tmo_cnt + 8'h01;
			if (r.tmo_cnt == r.sp3[sp][7:0]) begin
				n.as = AS_IDLE;
				n.sel_n = 4'hF;
				n.we_strb_n = 1'b1;
				n.rd_strb_n = 1'b1;
				n.oe_n = 1'b1;
				n.done = 1'b1;
				n.err = 1'b1;
				n.bus_err[ERR_TIME_BIT] = 1'b1;
				n.bus_err[ERR_SPACE_LSB + 32'(sp)] = 1'b1;
				if (acc_source <= 3'(ERR_BUS_MAX) && acc_source != 3'(ERR_BUS_RSVD)) begin
					n.bus_err[acc_source] = 1'b1;
				end
			end
		end

		// Engine restart leaves every configuration value alone
		if (restart) begin
			n.sd = SD_INIT_DEACT;
			n.as = AS_IDLE;
			n.gap = 4'h0;
			n.ras_cnt = 4'h0;
			n.rrd_cnt = 4'h0;
			n.turn_cnt = 3'h0;
			n.sel_n = 4'hF;
			n.cmd = CMD_NOP;
			n.a10 = 1'b0;
			n.we_strb_n = 1'b1;
			n.rd_strb_n = 1'b1;
			n.oe_n = 1'b1;
			n.done = 1'b0;
			n.err = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r <= '0;
			r.gctl <= GLOBAL_CTRL_RST;
			r.sp1 <= {4{SPACE_ONE_RST}};
			r.sp2 <= {4{SPACE_TWO_RST}};
			r.sp3 <= {4{SPACE_THREE_RST}};
			r.sd1 <= SD_CTRL1_RST;
			r.sd2 <= SD_CTRL2_RST;
			r.interval <= INTERVAL_RST;
			r.sd <= SD_INIT_DEACT;
			r.as <= AS_IDLE;
			r.sel_n <= 4'hF;
			r.cmd <= CMD_NOP;
			r.we_strb_n <= 1'b1;
			r.rd_strb_n <= 1'b1;
			r.oe_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Pins straight from the state flops
	assign reg_rdata = r.rdata;
	assign acc_done = r.done;
	assign acc_error = r.err;
	assign {space3_select_n, space2_select_n, space1_select_n, space0_select_n} = r.sel_n;
	assign async_write_strobe_n = r.we_strb_n;
	assign async_read_strobe_n = r.rd_strb_n;
	assign async_output_enable_n = r.oe_n;
	assign async_kind = r.kind;
	assign {row_strobe_n, column_strobe_n, sdram_we_n} = r.cmd;
	assign sdram_all_banks = r.a10;
	assign upper_lanes_on = r.sd2[ACCESS_WIDTH_BIT];
	assign part_width_x32 = r.sd1[PART_WIDTH_BIT];
	assign part_density_hi = r.sd1[PART_DENSITY_BIT];
endmodule
`default_nettype wire

// ---- rtl/emif_cfg_pkg.sv ----
// What this block does
// - Ratio code 001 halves the memory clock
// - Ratio code 000 runs memory clock full
// - Clock off holds memory clock high
// - Reset register write restarts engines, keeps config
// - Timeout sets one bus source bit, none for source 1 or 7
// - Timeout sets one space region bit
// - Bit 12 flags asynchronous access timeout
// - Error status read-only, cleared by read
// - SDRAM accesses never record bus errors
// - Memory kind 011 makes space SDRAM
// - Other kind codes select asynchronous widths
// - Setup, strobe, hold count CPU cycles
// - Timeout zero disables, N flags after N
// - Row cycle spaces refresh to next command
// - Precharge spaces deactivate to next command
// - Activate to read or write spacing
// - Active time, mode-set, activate spacings
// - Refresh enable gates all refreshes
// - Width and size bits select part type
// - Access width selects 16 or 32 lanes
// - Latency three, four clocks before deactivate
// - Same direction one, turnaround five clocks
// - Interval register, countdown register reads live
// - Trickle refresh only when no access pending
// - One SDRAM setting set, memory clock units
`default_nettype none
package emif_cfg_pkg;
	// Word addresses in I/O space
	localparam logic [15:0] ADDR_GLOBAL_CTRL = 16'h0800;
	localparam logic [15:0] ADDR_SM_RESET    = 16'h0801;
	localparam logic [15:0] ADDR_BUS_ERR     = 16'h0802;
	localparam logic [15:0] ADDR_SPACE_BASE  = 16'h0803;
	localparam logic [15:0] ADDR_SD_CTRL1    = 16'h080F;
	localparam logic [15:0] ADDR_INTERVAL    = 16'h0810;
	localparam logic [15:0] ADDR_COUNTDOWN   = 16'h0811;
	localparam logic [15:0] ADDR_SD_CTRL2    = 16'h0813;
	// Global control fields
	localparam int RATIO_LSB = 9;
	localparam int CLK_ON_BIT = 5;
	localparam logic [2:0] RATIO_FULL = 3'h0;
	localparam logic [2:0] RATIO_HALF = 3'h1;
	localparam logic [15:0] GLOBAL_CTRL_RST = 16'h0020;
	// Bus error status fields
	localparam int ERR_SPACE_LSB = 7;
	localparam int ERR_TIME_BIT = 12;
	localparam int ERR_BUS_RSVD = 1;
	localparam int ERR_BUS_MAX = 6;
	// Space control fields
	localparam int KIND_LSB = 12;
	localparam int SETUP_LSB = 8;
	localparam int STROBE_LSB = 2;
	localparam logic [2:0] KIND_SDRAM = 3'h3;
	localparam logic [15:0] SPACE_ONE_RST = 16'h2FFF;
	localparam logic [15:0] SPACE_TWO_RST = 16'h0FFF;
	localparam logic [15:0] SPACE_THREE_RST = 16'h0000;
	// SDRAM control one: trc, refresh_on, width, density, trp, trcd
	localparam int TRC_LSB = 12;
	localparam int REFRESH_ON_BIT = 11;
	localparam int PART_WIDTH_BIT = 10;
	localparam int PART_DENSITY_BIT = 9;
	localparam int TRP_LSB = 4;
	localparam int TRCD_LSB = 0;
	localparam logic [15:0] SD_CTRL1_RST = 16'hF0FF;
	// SDRAM control two: access width, activate spacing, tmrd, tras
	localparam int ACCESS_WIDTH_BIT = 12;
	localparam int ACT_SPACING_LSB = 8;
	localparam int TMRD_LSB = 4;
	localparam int TRAS_LSB = 0;
	localparam logic [15:0] SD_CTRL2_RST = 16'h0FFF;
	localparam logic [15:0] INTERVAL_RST = 16'h0100;
	// Fixed SDRAM spacings in memory clocks
	localparam int COL_LATENCY = 3;
	localparam int RW_TO_DEACT = 4;
	localparam int SAME_DIR_GAP = 1;
	localparam int TURN_GAP = 5;
endpackage
`default_nettype wire

// ---- rtl/mem_clock_gen.sv ----
`default_nettype none
module mem_clock_gen (
	input  wire logic       mclk,            // CPU clock
	input  wire logic       rst,             // Sync reset
	input  wire logic [2:0] mem_clock_ratio, // Rate code
	input  wire logic       mem_clock_on,    // Clock enable
	output logic            mem_tick,        // One memory clock
	output logic            memory_clock     // Memory clock pin
);
	import emif_cfg_pkg::*;

	typedef struct packed {
		logic phase;
		logic clk_lvl;
	} clk_state_s;

	clk_state_s st_r;
	clk_state_s st_nxt;

	// Reserved codes fall back to the half rate, the slower safe choice
	always_comb begin
		st_nxt = st_r;
		st_nxt.phase = ~st_r.phase;
		mem_tick = mem_clock_on && ((mem_clock_ratio == RATIO_FULL) || st_r.phase);
		if (!mem_clock_on) begin
			st_nxt.clk_lvl = 1'b1;
		end else if (mem_tick) begin
			st_nxt.clk_lvl = ~st_r.clk_lvl;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= '{phase: 1'b0, clk_lvl: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign memory_clock = st_r.clk_lvl;
endmodule
`default_nettype wire

// ---- rtl/refresh_countdown_unit.sv ----
`default_nettype none
module refresh_countdown_unit #(
	parameter int CW = 16 // Counter width
) (
	input  wire logic          mclk,        // CPU clock
	input  wire logic          rst,         // Sync reset
	input  wire logic          restart,     // Engine restart
	input  wire logic          mem_tick,    // Memory clock enable
	input  wire logic [CW-1:0] interval,    // Reload value
	input  wire logic          refresh_on,  // Refresh enable
	input  wire logic          taken,       // Sequencer took it
	output logic [CW-1:0]      count,       // Live count
	output logic               refresh_req  // Pending request
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          req;
	} cnt_state_s;

	cnt_state_s st_r;
	cnt_state_s st_nxt;

	// Count down per memory clock, reload and request at zero
	always_comb begin
		st_nxt = st_r;
		if (taken) begin
			st_nxt.req = 1'b0;
		end
		if (mem_tick) begin
			if (st_r.cnt == '0) begin
				st_nxt.cnt = interval;
				st_nxt.req = refresh_on;
			end else begin
				st_nxt.cnt = st_r.cnt - 1'b1;
			end
		end
		if (!refresh_on) begin
			st_nxt.req = 1'b0;
		end
		if (restart) begin
			st_nxt = '{cnt: interval, req: 1'b0};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count = st_r.cnt;
	assign refresh_req = st_r.req;
endmodule
`default_nettype wire

// ---- tb/emif_timing_assertions.sv ----
`default_nettype none
module emif_timing_checker (
	input wire logic        mclk,            // Clock
	input wire logic        rst,             // Reset
	input wire logic [15:0] reg_addr,        // Address
	input wire logic        reg_wr,          // Write
	input wire logic        reg_rd,          // Read
	input wire logic [15:0] reg_wdata,       // Write data
	input wire logic [15:0] reg_rdata,       // Read data
	input wire logic        acc_req,         // Request
	input wire logic        acc_done,        // Done
	input wire logic        acc_error,       // Error
	input wire logic        memory_clock,    // Memory clock
	input wire logic        space0_select_n, // Select 0
	input wire logic        space1_select_n, // Select 1
	input wire logic        space2_select_n, // Select 2
	input wire logic        space3_select_n, // Select 3
	input wire logic        row_strobe_n,    // Row strobe
	input wire logic        column_strobe_n, // Column strobe
	input wire logic        sdram_we_n,      // SDRAM write
	input wire logic        sdram_all_banks,      // All banks
	input wire logic        async_write_strobe_n, // Async write strobe
	input wire logic        async_read_strobe_n,  // Async read strobe
	input wire logic        async_output_enable_n // Async output enable
);
	import emif_cfg_pkg::*;
	logic       on_r;
	logic       rw_cmd;
	logic       dact_cmd;
	logic [3:0] sel_n;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Own copy of the clock enable, the design's one is hidden
	always_ff @(posedge mclk) begin
		if (rst)
			on_r <= 1'b1;
		else if (reg_wr && reg_addr == ADDR_GLOBAL_CTRL)
			on_r <= reg_wdata[CLK_ON_BIT];
	end
	// Command decode from the pins
	assign rw_cmd = row_strobe_n && !column_strobe_n;
	assign dact_cmd = !row_strobe_n && column_strobe_n && !sdram_we_n;
	assign sel_n = {space3_select_n, space2_select_n, space1_select_n, space0_select_n};
	done_pulse_a: assert property (acc_done |=> !acc_done)
		else $error("done held past one cycle");
	error_done_a: assert property (acc_error |-> acc_done)
		else $error("error without done");
	done_req_a: assert property (acc_done |-> $past(acc_req))
		else $error("done without request");
	// Refresh, mode set and deactivate reach every SDRAM space at once
	one_space_a: assert property (row_strobe_n |-> $onehot0(~sel_n))
		else $error("two spaces selected");
	read_oe_a: assert property (!async_read_strobe_n |-> !async_output_enable_n && async_write_strobe_n)
		else $error("output enable not low during read strobe");
	reset_idle_a: assert property ($fell(rst) |-> memory_clock && &sel_n && row_strobe_n)
		else $error("outputs not idle after reset");
	clock_off_a: assert property (!on_r [*3] |-> memory_clock)
		else $error("memory clock not held high");
	reset_reg_a: assert property (reg_rd && reg_addr == ADDR_SM_RESET |=> reg_rdata == 16'h0000)
		else $error("reset register read not zero");
	deact_banks_a: assert property (dact_cmd |-> sdram_all_banks)
		else $error("deactivate without all banks");
	rw_deact_a: assert property (rw_cmd |=> !dact_cmd [*3])
		else $error("deactivate too soon after column command");
endmodule
`default_nettype wire

// ---- tb/async_mem_model.sv ----
`default_nettype none
module async_mem_model (
	input  wire logic mclk,       // Clock
	input  wire logic strobe_n,   // Any strobe low
	input  wire logic stall,      // Hold off ready
	input  wire logic slow,       // Add one wait
	output logic      async_ready // Ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic toggle_r = 1'b0;
	logic wait_r = 1'b0;
	// Idle ready wanders so no stale level is trusted
	always_ff @(posedge mclk) begin
		toggle_r <= !toggle_r;
		wait_r <= !strobe_n;
	end
	// In the strobe phase, ready at once or one cycle late
	assign async_ready = strobe_n ? toggle_r : (!stall && (!slow || wait_r));
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import emif_cfg_pkg::*;
	localparam logic [2:0] KINDS [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        acc_req = 1'b0;
	logic        acc_write = 1'b0;
	logic        stall = 1'b0;
	logic        slow = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic [1:0]  acc_space = 2'h0;
	logic [2:0]  acc_source = 3'h0;
	logic [15:0] reg_rdata;
	logic [2:0]  async_kind;
	logic acc_done, acc_error, async_ready, memory_clock, space0_select_n, space1_select_n;
	logic space2_select_n, space3_select_n, async_write_strobe_n, async_read_strobe_n;
	logic async_output_enable_n, row_strobe_n, column_strobe_n, sdram_we_n, sdram_all_banks;
	logic upper_lanes_on, part_width_x32, part_density_hi;
	int          errors = 0;
	int          checks_done = 0;
	// Block and far-side memory
	emif_timing_ctrl i_emif_timing_ctrl (
		.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .acc_req, .acc_space,
		.acc_write, .acc_source, .acc_done, .acc_error, .async_ready, .memory_clock,
		.space0_select_n, .space1_select_n, .space2_select_n, .space3_select_n,
		.async_write_strobe_n, .async_read_strobe_n, .async_output_enable_n, .async_kind,
		.row_strobe_n, .column_strobe_n, .sdram_we_n, .sdram_all_banks, .upper_lanes_on,
		.part_width_x32, .part_density_hi
	);
	async_mem_model i_async_mem_model (
		.mclk, .strobe_n(async_read_strobe_n & async_write_strobe_n), .stall, .slow, .async_ready
	);
	always #20 mclk = ~mclk;
	// Verdict, reached from the end of the run or a spent wait
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] v, input logic [15:0] e);
		checks_done++;
		if (v !== e) begin
			errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, v, e);
		end
	endtask
	// Register bus, one pulse per word, driven on the falling edge
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask
	task automatic rdc(input logic [15:0] a, input logic [15:0] e);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask
	// Request held until done, wait bounded
	task automatic acc(input logic [1:0] s, input logic w, input logic [2:0] b,
			output int lat, output logic e);
		lat = 0;
		@(negedge mclk);
		acc_space = s;
		acc_write = w;
		acc_source = b;
		acc_req = 1'b1;
		while (acc_done !== 1'b1 && lat < 600) begin
			@(negedge mclk);
			lat++;
		end
		e = acc_error;
		acc_req = 1'b0;
		if (lat >= 600) begin
			errors++;
			results();
		end
	endtask
	// Rising edges and high samples of the memory clock over 40 cycles
	task automatic mc(output int r, output int h);
		logic p;
		r = 0;
		h = 0;
		p = memory_clock;
		repeat (40) begin
			@(negedge mclk);
			r += int'(p === 1'b0 && memory_clock === 1'b1);
			h += int'(memory_clock === 1'b1);
			p = memory_clock;
		end
	endtask
	function automatic logic [15:0] exp_err(input logic [1:0] s, input logic [2:0] b);
		return (16'h0001 << ERR_TIME_BIT) | (16'h0001 << (ERR_SPACE_LSB + s)) | (16'h0001 << b);
	endfunction
	// Main sequence
	initial begin
		int lat, r, h, k, n;
		logic e;
		logic [1:0] s;
		logic [2:0] src, kd;
		logic [15:0] c;
		void'($urandom(88));
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		rdc(ADDR_GLOBAL_CTRL, GLOBAL_CTRL_RST);
		rdc(ADDR_SPACE_BASE, SPACE_ONE_RST);
		rdc(ADDR_SD_CTRL1, SD_CTRL1_RST);
		rdc(ADDR_INTERVAL, INTERVAL_RST);
		rdc(ADDR_BUS_ERR, 16'h0000);
		rdc(16'h0812, 16'h0000);
		mc(r, h);
		chk(16'(r), 16'd20);
		// Rate is changed only while the clock is off
		wr(ADDR_GLOBAL_CTRL, 16'h0000);
		repeat (2) @(negedge mclk);
		mc(r, h);
		chk(16'(h), 16'd40);
		wr(ADDR_GLOBAL_CTRL, 16'h0200);
		wr(ADDR_GLOBAL_CTRL, 16'h0220);
		repeat (4) @(negedge mclk);
		mc(r, h);
		chk(16'(r), 16'd10);
		// Engine restart keeps settings, countdown runs
		wr(ADDR_INTERVAL, 16'h0030);
		wr(ADDR_SM_RESET, 16'h0000);
		rdc(ADDR_INTERVAL, 16'h0030);
		rdc(ADDR_SM_RESET, 16'h0000);
		@(negedge mclk);
		reg_addr = ADDR_COUNTDOWN;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		c = reg_rdata;
		repeat (6) @(negedge mclk);
		// Eight CPU cycles at half rate are four memory clocks
		rdc(ADDR_COUNTDOWN, c - 16'd4);
		chk(16'(c !== reg_rdata && reg_rdata <= 16'h0030), 16'h0001);
		// Part type and lane pins, one width for every SDRAM space
		for (k = 0; k < 4; k++) begin
			wr(ADDR_SD_CTRL1, 16'h1811 | (16'(k) << PART_DENSITY_BIT));
			wr(ADDR_SD_CTRL2, 16'h0111 | (16'(k % 2) << ACCESS_WIDTH_BIT));
			chk({13'h0, upper_lanes_on, part_width_x32, part_density_hi},
				{13'h0, 1'(k % 2), 1'(k / 2), 1'(k % 2)});
		end
		// Timeouts on async kinds 000, 001, 010, 100, SDRAM spaces, then plain async
		for (k = 0; k < 10; k++) begin
			s = 2'(k);
			kd = k < 4 ? KINDS[k] : (k < 8 ? KIND_SDRAM : 3'h2);
			n = k < 8 ? $urandom_range(1, 8) : 0;
			src = k == 0 ? 3'h0 : 3'($urandom_range(2, 6));
			stall = k < 4;
			slow = k < 8 ? 1'($urandom_range(0, 1)) : 1'b0;
			// Refresh off so no refresh slot delays the latency check
			if (k == 8)
				wr(ADDR_SD_CTRL1, 16'h1011);
			wr(ADDR_SPACE_BASE + 16'(s) * 16'h0003, {1'b0, kd, 12'h105});
			wr(ADDR_SPACE_BASE + 16'(s) * 16'h0003 + 16'h0002, 16'(n));
			acc(s, k < 8 ? 1'($urandom_range(0, 1)) : 1'(k % 2), src, lat, e);
			chk(16'(e), 16'(k < 4));
			if (k < 4) begin
				chk(16'(lat >= n && lat <= n + 3), 16'h0001);
				chk(16'(async_kind), 16'(kd));
			end
			if (k == 8)
				chk(16'(lat), 16'd4);
			rdc(ADDR_BUS_ERR, k < 4 ? exp_err(s, src) : 16'h0000);
			rdc(ADDR_BUS_ERR, 16'h0000);
		end
		results();
	end
endmodule
bind emif_timing_ctrl emif_timing_checker i_emif_timing_checker (
	.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .acc_req, .acc_done,
	.acc_error, .memory_clock, .space0_select_n, .space1_select_n, .space2_select_n,
	.space3_select_n, .row_strobe_n, .column_strobe_n, .sdram_we_n, .sdram_all_banks,
	.async_write_strobe_n, .async_read_strobe_n, .async_output_enable_n
);
`default_nettype wire
